// File: include/eye_window_pkg.sv
package eye_window_pkg;

  // eye word and frame layout
  localparam int unsigned EYE_WORD_W = 19;
  localparam int unsigned DAC_W      = 8;
  localparam int unsigned POS_W      = 5;
  localparam int unsigned FCNT_W     = 5;

  // frame positions: start bit at 0, eye bits msb first at 1..19
  localparam logic [FCNT_W-1:0] FRAME_FIRST_BIT = 5'h01;
  localparam logic [FCNT_W-1:0] FRAME_EYE_LAST  = 5'h13;
  localparam logic [FCNT_W-1:0] FRAME_LAST      = 5'h1D;

  // window top bit limits inside the eye word
  localparam logic [POS_W-1:0] POS_MIN   = 5'h07;
  localparam logic [POS_W-1:0] POS_MAX   = 5'h12;
  localparam logic [POS_W-1:0] POS_RESET = 5'h12;

  // timing
  localparam int unsigned MCLK_PERIOD_NS = 50;
  localparam int unsigned BAUD_PERIOD_NS = 12500;
  localparam int unsigned BAUD_CYCLES    = BAUD_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int unsigned LOSS_CYCLES    = 2 * BAUD_CYCLES;
  localparam int unsigned LOSS_W         = 10;
  localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(LOSS_CYCLES);

  // automatic placement: words observed per settling span
  localparam int unsigned SPAN_W        = 6;
  localparam logic [SPAN_W-1:0] SPAN_LAST = 6'h3F;

  localparam logic [2:0] SHIFT_LAST = 3'h7;

  typedef enum logic [1:0] {
    LK_IDLE  = 2'b01,
    LK_FRAME = 2'b10
  } link_state_t;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_LATCH = 3'b100
  } ser_state_t;

endpackage : eye_window_pkg

// File: include/s2p_if.sv
`timescale 1ns/100ps
`default_nettype none
interface s2p_if;
  logic       ser_bit;
  logic       shift_en;
  logic [7:0] par;

  modport drv (output ser_bit, output shift_en, input par);
  modport s2p (input ser_bit, input shift_en, output par);
endinterface : s2p_if
`default_nettype wire

// File: hdl/serial_to_parallel.sv
`timescale 1ns/100ps
`default_nettype none
module serial_to_parallel
  import eye_window_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic srst_i,
  s2p_if.s2p        link
);

  // bits enter at the lsb, so the first bit shifted ends up as the msb
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      link.par <= 8'h00;
    end else if (link.shift_en) begin
      link.par <= {link.par[6:0], link.ser_bit};
    end
  end

endmodule : serial_to_parallel
`default_nettype wire

// File: hdl/eye_pattern_window_extractor.sv
`timescale 1ns/100ps
`default_nettype none
module eye_pattern_window_extractor
  import eye_window_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             sample_shift_clock_i,
  input  wire logic             eye_sample_out_i,
  input  wire logic [POS_W-1:0] win_pos_i,
  input  wire logic             auto_en_i,
  output logic      [DAC_W-1:0] dac_data_o,
  output logic                  dac_latch_o,
  output logic      [POS_W-1:0] win_pos_o,
  output logic                  eye_lost_o
);

  // ---------------- link domain ----------------
  logic [1:0]            lrst_sync;
  link_state_t           lstate;
  logic [FCNT_W-1:0]     bit_cnt;
  logic [EYE_WORD_W-1:0] shreg;
  logic [EYE_WORD_W-1:0] word_hold;
  logic                  word_tog;

  // reset reaches the link side only while its clock runs
  always_ff @(posedge sample_shift_clock_i) begin
    lrst_sync <= {lrst_sync[0], srst_i};
  end

  always_ff @(posedge sample_shift_clock_i) begin
    if (lrst_sync[1]) begin
      lstate  <= LK_IDLE;
      bit_cnt <= 5'h00;
    end else begin
      case (lstate)
        LK_IDLE: begin
          // idle line is low, first high sample is the start bit
          if (eye_sample_out_i) begin
            lstate  <= LK_FRAME;
            bit_cnt <= FRAME_FIRST_BIT;
          end
        end
        LK_FRAME: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == FRAME_LAST) begin
            lstate <= LK_IDLE;
          end
        end
        default: begin
          lstate  <= LK_IDLE;
          bit_cnt <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sample_shift_clock_i) begin
    if (lrst_sync[1]) begin
      shreg <= '0;
    end else if (lstate == LK_FRAME && bit_cnt <= FRAME_EYE_LAST) begin
      shreg <= {shreg[EYE_WORD_W-2:0], eye_sample_out_i};
    end
  end

  // held word stays still for a whole baud, long enough for the crossing
  always_ff @(posedge sample_shift_clock_i) begin
    if (lrst_sync[1]) begin
      word_hold <= '0;
      word_tog  <= 1'b0;
    end else if (lstate == LK_FRAME && bit_cnt == FRAME_EYE_LAST) begin
      word_hold <= {shreg[EYE_WORD_W-2:0], eye_sample_out_i};
      word_tog  <= ~word_tog;
    end
  end

  // ---------------- system domain ----------------
  logic [1:0]            tog_sync;
  logic                  tog_prev;
  logic                  new_word;
  logic                  word_ready;
  logic [EYE_WORD_W-1:0] eye_word;
  logic [POS_W-1:0]      pos_sync0;
  logic [POS_W-1:0]      pos_sync1;
  logic [1:0]            auto_sync;
  logic [POS_W-1:0]      man_pos;
  logic [POS_W-1:0]      word_pos;
  logic [POS_W-1:0]      auto_pos;
  logic [POS_W-1:0]      peak_pos;
  logic [SPAN_W-1:0]     span_cnt;
  logic [POS_W-1:0]      next_pos;
  logic [DAC_W-1:0]      window;
  logic [LOSS_W-1:0]     loss_cnt;
  ser_state_t            sstate;
  logic [DAC_W-1:0]      ser_reg;
  logic [2:0]            ser_cnt;

  s2p_if s2p_bus ();

  serial_to_parallel u_s2p (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .link   (s2p_bus.s2p)
  );

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tog_sync  <= 2'h0;
      tog_prev  <= 1'b0;
      pos_sync0 <= POS_RESET;
      pos_sync1 <= POS_RESET;
      auto_sync <= 2'h0;
    end else begin
      tog_sync  <= {tog_sync[0], word_tog};
      tog_prev  <= tog_sync[1];
      pos_sync0 <= win_pos_i;
      pos_sync1 <= pos_sync0;
      auto_sync <= {auto_sync[0], auto_en_i};
    end
  end

  assign new_word = tog_sync[1] ^ tog_prev;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      eye_word   <= '0;
      word_ready <= 1'b0;
    end else begin
      word_ready <= new_word;
      if (new_word) begin
        eye_word <= word_hold;
      end
    end
  end

  // lowest bit of the run of sign copies is the true sign bit
  function automatic logic [POS_W-1:0] sign_top(
    input logic [EYE_WORD_W-1:0] w
  );
    logic [POS_W-1:0] k;
    k = 5'h00;
    for (int i = 0; i < EYE_WORD_W - 1; i++) begin
      if (w[i] != w[EYE_WORD_W-1]) begin
        k = POS_W'(i + 1);
      end
    end
    if (k < POS_MIN) begin
      k = POS_MIN;
    end
    return k;
  endfunction : sign_top

  always_comb begin
    word_pos = sign_top(eye_word);
    if (pos_sync1 < POS_MIN) begin
      man_pos = POS_MIN;
    end else if (pos_sync1 > POS_MAX) begin
      man_pos = POS_MAX;
    end else begin
      man_pos = pos_sync1;
    end
    next_pos = auto_sync[1] ? auto_pos : man_pos;
    window   = DAC_W'(eye_word >> (next_pos - POS_MIN));
  end

  // auto placement follows the peak of a span of words rather than each
  // word, trading response time for a window that does not flicker
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      auto_pos <= POS_RESET;
      peak_pos <= POS_MIN;
      span_cnt <= '0;
    end else if (word_ready) begin
      span_cnt <= span_cnt + 6'h01;
      if (span_cnt == SPAN_LAST) begin
        auto_pos <= (word_pos > peak_pos) ? word_pos : peak_pos;
        peak_pos <= POS_MIN;
      end else if (word_pos > peak_pos) begin
        peak_pos <= word_pos;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sstate  <= SER_IDLE;
      ser_reg <= 8'h00;
      ser_cnt <= 3'h0;
    end else begin
      case (sstate)
        SER_IDLE: begin
          if (word_ready) begin
            ser_reg <= window;
            ser_cnt <= 3'h0;
            sstate  <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          ser_reg <= {ser_reg[DAC_W-2:0], 1'b0};
          ser_cnt <= ser_cnt + 3'h1;
          if (ser_cnt == SHIFT_LAST) begin
            sstate <= SER_LATCH;
          end
        end
        SER_LATCH: begin
          sstate <= SER_IDLE;
        end
        default: begin
          sstate <= SER_IDLE;
        end
      endcase
    end
  end

  assign s2p_bus.ser_bit  = ser_reg[DAC_W-1];
  assign s2p_bus.shift_en = (sstate == SER_SHIFT);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dac_data_o  <= 8'h00;
      dac_latch_o <= 1'b0;
      win_pos_o   <= POS_RESET;
    end else begin
      dac_latch_o <= (sstate == SER_LATCH);
      if (sstate == SER_LATCH) begin
        dac_data_o <= s2p_bus.par;
      end
      if (word_ready) begin
        win_pos_o <= next_pos;
      end
    end
  end

  // a silent eye line usually means the transceiver output is not enabled
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      loss_cnt   <= '0;
      eye_lost_o <= 1'b1;
    end else if (new_word) begin
      loss_cnt   <= '0;
      eye_lost_o <= 1'b0;
    end else if (loss_cnt == LOSS_LIMIT) begin
      eye_lost_o <= 1'b1;
    end else begin
      loss_cnt <= loss_cnt + 10'h001;
    end
  end

endmodule : eye_pattern_window_extractor
`default_nettype wire

// File: verif/eye_window_properties.sv
`timescale 1ns/100ps
`default_nettype none
module eye_window_properties
  import eye_window_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             srst_i,
  input wire logic             sample_shift_clock_i,
  input wire logic             eye_sample_out_i,
  input wire logic [POS_W-1:0] win_pos_i,
  input wire logic             auto_en_i,
  input wire logic [DAC_W-1:0] dac_data_o,
  input wire logic             dac_latch_o,
  input wire logic [POS_W-1:0] win_pos_o,
  input wire logic             eye_lost_o
);
  logic [4:0]  n = 5'h00;
  logic [18:0] w;
  logic        t = 1'b0;
  logic [2:0]  ts = 3'h0;
  logic [9:0]  qt;
  // own frame tracker, so the data check does not lean on the design
  always_ff @(posedge sample_shift_clock_i) begin
    if (n != 5'h00) n <= (n == FRAME_LAST) ? 5'h00 : n + 5'h01;
    else if (eye_sample_out_i) n <= 5'h01;
    if (n != 5'h00 && n <= FRAME_EYE_LAST) w <= {w[17:0], eye_sample_out_i};
    if (n == FRAME_EYE_LAST) t <= ~t;
  end
  always_ff @(posedge mclk_i) ts <= {ts[1:0], t};
  always_ff @(posedge mclk_i) begin
    if (srst_i || dac_latch_o) qt <= 10'h000;
    else if (qt != 10'h3FF) qt <= qt + 10'h001;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  reset_vals_a: assert property ($fell(srst_i) |-> dac_data_o == 8'h00 &&
    !dac_latch_o && win_pos_o == POS_RESET && eye_lost_o)
    else $error("outputs not at reset values");
  latch_pulse_a: assert property (dac_latch_o |=> !dac_latch_o [*8])
    else $error("latch pulse too long or too close");
  data_hold_a: assert property (!dac_latch_o |-> $stable(dac_data_o))
    else $error("dac data moved without latch");
  pos_range_a: assert property (win_pos_o >= POS_MIN && win_pos_o <= POS_MAX)
    else $error("window position out of range");
  window_data_a: assert property (dac_latch_o |->
    dac_data_o == w[win_pos_o -: 8])
    else $error("dac value is not the window of the word");
  word_latency_a: assert property (ts[2] != ts[1] |-> ##[8:18] dac_latch_o)
    else $error("no latch after a received word");
  lost_clear_a: assert property (dac_latch_o |-> !eye_lost_o)
    else $error("loss flag high while words arrive");
  lost_quiet_a: assert property (qt > 10'h208 |-> eye_lost_o)
    else $error("loss flag low after long silence");
  cover property (dac_latch_o && win_pos_o == POS_MIN);
  cover property (dac_latch_o && win_pos_o == 5'h09);
  cover property ($rose(eye_lost_o));
endmodule : eye_window_properties
`default_nettype wire

// File: verif/eye_source.sv
`timescale 1ns/100ps
`default_nettype none
module eye_source (
  output logic sample_shift_clock_o,
  output logic eye_sample_out_o
);
  // runs as though the diagnostic enable bit were set; clock is free running
  initial begin
    sample_shift_clock_o = 1'b0;
    forever #16 sample_shift_clock_o = ~sample_shift_clock_o;
  end
  initial eye_sample_out_o = 1'b0;
  task automatic send(input logic [18:0] w);
    logic [29:0] f;
    f = {1'b1, w, 10'($urandom)};
    for (int i = 29; i >= 0; i--) begin
      @(negedge sample_shift_clock_o);
      eye_sample_out_o = f[i];
    end
    @(negedge sample_shift_clock_o);
    eye_sample_out_o = 1'b0;
    repeat (96 + $urandom % 3) @(negedge sample_shift_clock_o);
  endtask : send
endmodule : eye_source
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import eye_window_pkg::*;
  typedef struct packed {logic [7:0] d; logic [4:0] p;} exp_t;
  logic       mclk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       auto_en = 1'b0;
  logic       skip = 1'b0;
  logic [4:0] pos = 5'h00;
  wire        lclk, eye, latch, lost;
  wire  [4:0] wpos;
  wire  [7:0] dac;
  int         n_errors = 0;
  int         checked = 0;
  exp_t       q[$];
  exp_t       e;
  initial forever #25 mclk_i = ~mclk_i;
  eye_source src (.sample_shift_clock_o(lclk), .eye_sample_out_o(eye));
  eye_pattern_window_extractor uut (.mclk_i(mclk_i), .srst_i(srst_i),
    .sample_shift_clock_i(lclk), .eye_sample_out_i(eye), .win_pos_i(pos),
    .auto_en_i(auto_en), .dac_data_o(dac), .dac_latch_o(latch),
    .win_pos_o(wpos), .eye_lost_o(lost));
  task automatic cmp(string s, logic [7:0] x, logic [7:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, x, g);
    end
  endtask : cmp
  task automatic close_out;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic word(input logic [4:0] t, input int k, input bit c);
    logic [18:0] w;
    w = 19'($urandom);
    for (int i = 18; i > k; i--) w[i] = w[k];
    w[k-1] = ~w[k];
    if (c) q.push_back({w[t -: 8], t});
    src.send(w);
    for (int i = 0; i < 400 && q.size() != 0; i++) @(posedge mclk_i);
    if (q.size() != 0) begin
      n_errors++;
      close_out();
    end
  endtask : word
  // outputs are looked at mid-cycle, well clear of the edge that moves them
  always @(negedge mclk_i) begin
    if (latch === 1'b1 && !skip) begin
      if (q.size() == 0) cmp("extra_latch", 8'h00, 8'h01);
      else begin
        e = q.pop_front();
        cmp("dac", e.d, dac);
        cmp("pos", {3'h0, e.p}, {3'h0, wpos});
      end
    end
  end
  initial begin
    void'($urandom(54915));
    repeat (16) @(negedge mclk_i);
    cmp("rst_lost", 8'h01, {7'h00, lost});
    cmp("rst_pos", {3'h0, POS_RESET}, {3'h0, wpos});
    srst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    for (int p = 0; p < 32; p++) begin
      @(negedge mclk_i) pos = 5'(p);
      word(p < 7 ? POS_MIN : p > 18 ? POS_MAX : 5'(p),
        7 + $urandom % 12, 1'b1);
    end
    cmp("lost", 8'h00, {7'h00, lost});
    $display("done manual");
    repeat (600) @(negedge mclk_i);
    cmp("lost", 8'h01, {7'h00, lost});
    $display("done loss");
    srst_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    srst_i = 1'b0;
    auto_en = 1'b1;
    skip = 1'b1;
    // link side leaves reset only after two of its own edges; a start bit
    // sent sooner is lost and the settling span comes up one word short
    repeat (4) @(negedge mclk_i);
    // settling span: window before the first span ends is not checked
    repeat (64) word(POS_MAX, 9, 1'b0);
    @(negedge mclk_i) skip = 1'b0;
    repeat (4) word(5'h09, 9, 1'b1);
    $display("done auto");
    @(negedge mclk_i) auto_en = 1'b0;
    pos = 5'h0C;
    repeat (3) word(5'h0C, 7 + $urandom % 12, 1'b1);
    $display("done override");
    close_out();
  end
endmodule : tb
bind eye_pattern_window_extractor eye_window_properties chk (
  .mclk_i(mclk_i), .srst_i(srst_i),
  .sample_shift_clock_i(sample_shift_clock_i),
  .eye_sample_out_i(eye_sample_out_i), .win_pos_i(win_pos_i),
  .auto_en_i(auto_en_i), .dac_data_o(dac_data_o), .dac_latch_o(dac_latch_o),
  .win_pos_o(win_pos_o), .eye_lost_o(eye_lost_o));
`default_nettype wire
